/* core/eiv_top.v */
// External interrupt detection, flags and vector selection.
// Assumes pins are asynchronous inputs and a Wishbone classic master.
`timescale 1ns/1ps
`include "eiv_consts.vh"
// Functional notes
// - Every reset source starts execution at vector word 0x0000.
// - Dedicated interrupt pin request uses vector 0x0001.
// - Lower pin-change group at 0x0002, upper group at 0x0003.
// - 16-bit timer capture, compare A, compare B, overflow at 0x0005-0x0008.
// - 8-bit timer compare A, compare B, overflow at 0x0009-0x000B.
// - Watchdog 0x0004; comparator through serial overflow 0x000C-0x0010.
// - Pins trigger even when driven as outputs by the device.
// - Any enabled toggle on inputs 0 to 7 raises lower group request.
// - Any enabled toggle on inputs 8 to 11 raises upper group request.
// - Only mask-selected pins contribute to their group request.
// - Pin changes are detected without the I/O clock for wake-up.
// - Dedicated pin triggers on falling, rising edge or low level.
// - Low-level mode keeps the request asserted while the pin is low.
// - Edges on the dedicated pin are seen only with I/O clock running.
// - Low level on dedicated pin is detected without the I/O clock.
// - Low level gone before wake completes means no handler branch.
// - Sense field: 00 low, 01 any change, 10 falling, 11 rising.
// - Edge pulses longer than one clock period are caught while the I/O clock runs.
// - Flags set by events, cleared by vector execution or writing one.
// - A pin is enabled only when mask bit and group enable are set.
module eiv_top #(
  parameter NPC = 12,
  parameter NLO = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire ext_irq_pin_i,
  input wire [NPC-1:0] pin_change_inputs_i,
  input wire io_clk_run_i,
  input wire [12:0] periph_req_i,
  input wire vec_taken_i,
  input wire [4:0] vec_taken_addr_i,
  output reg irq_req_o,
  output reg [4:0] irq_vec_o,
  output reg wake_o,
  output reg [4:0] reset_vec_o
);
  // ==========================================================
  // Pin synchronisers; stage one is read only by stage two.
  reg ext_s1_r, ext_s2_r, ext_prev_r;
  reg [NPC-1:0] pc_s1_r, pc_s2_r, pc_prev_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      ext_prev_r <= 1'b1;
      pc_s1_r <= {NPC{1'b0}};
      pc_s2_r <= {NPC{1'b0}};
      pc_prev_r <= {NPC{1'b0}};
    end else begin
      ext_s1_r <= ext_irq_pin_i;
      ext_s2_r <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
      pc_s1_r <= pin_change_inputs_i;
      pc_s2_r <= pc_s1_r;
      pc_prev_r <= pc_s2_r;
    end
  end
  // ==========================================================
  // Registers.
  reg [1:0] sense_r;
  reg en_ext_r, en_pclo_r, en_pchi_r;
  reg [NLO-1:0] mask_lo_r;
  reg [NPC-NLO-1:0] mask_hi_r;
  reg flg_ext_r, flg_pclo_r, flg_pchi_r;
  // ==========================================================
  // Pin-change detection per pin.
  wire [NPC-1:0] pc_hit;
  genvar g;
  generate
    for (g = 0; g < NPC; g = g + 1) begin : g_pc
      wire msk;
      if (g < NLO) begin : g_lo
        assign msk = mask_lo_r[g] & en_pclo_r;
      end else begin : g_hi
        assign msk = mask_hi_r[g-NLO] & en_pchi_r;
      end
      // Toggle compare needs no I/O clock gate, only the system clock.
      assign pc_hit[g] = msk & (pc_s2_r[g] ^ pc_prev_r[g]);
    end
  endgenerate
  wire pclo_ev = |pc_hit[NLO-1:0];
  wire pchi_ev = |pc_hit[NPC-1:NLO];
  // ==========================================================
  // Dedicated pin sensing.
  wire ext_low = ~ext_s2_r;
  wire ext_fall = ext_prev_r & ~ext_s2_r;
  wire ext_rise = ~ext_prev_r & ext_s2_r;
  reg ext_edge;
  always @* begin
    case (sense_r)
      `EIV_SENSE_ANY: ext_edge = ext_fall | ext_rise;
      `EIV_SENSE_FALL: ext_edge = ext_fall;
      `EIV_SENSE_RISE: ext_edge = ext_rise;
      default: ext_edge = 1'b0;
    endcase
  end
  // Edges need the I/O clock; a two-cycle-wide pulse is always seen.
  wire ext_edge_ev = ext_edge & io_clk_run_i;
  wire level_mode = (sense_r == `EIV_SENSE_LOW);
  // Level request is live from the pin, never latched, so a level that
  // vanishes before wake-up leaves nothing pending.
  wire ext_level_req = level_mode & ext_low & en_ext_r;
  // ==========================================================
  // Bus decode.
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
  wire [7:0] ofs = {wb_adr_i[7:2], 2'b00};
  wire [7:0] wd = wb_dat_i[7:0];
  wire flag_wr = wb_wr & (ofs == `EIV_FLAG_OFS);
  wire clr_ext = (flag_wr & wd[`EIV_FLG_EXT_BIT]) |
    (vec_taken_i & vec_taken_addr_i == `EIV_VEC_EXT);
  wire clr_pclo = (flag_wr & wd[`EIV_FLG_PCLO_BIT]) |
    (vec_taken_i & vec_taken_addr_i == `EIV_VEC_PC_LO);
  wire clr_pchi = (flag_wr & wd[`EIV_FLG_PCHI_BIT]) |
    (vec_taken_i & vec_taken_addr_i == `EIV_VEC_PC_HI);
  // ==========================================================
  // Flags: set wins over clear; edge flag is held clear in level mode.
  always @(posedge clk_i) begin
    if (rst_i) begin
      flg_ext_r <= 1'b0;
      flg_pclo_r <= 1'b0;
      flg_pchi_r <= 1'b0;
    end else begin
      if (level_mode)
        flg_ext_r <= 1'b0;
      else if (ext_edge_ev)
        flg_ext_r <= 1'b1;
      else if (clr_ext)
        flg_ext_r <= 1'b0;
      if (pclo_ev)
        flg_pclo_r <= 1'b1;
      else if (clr_pclo)
        flg_pclo_r <= 1'b0;
      if (pchi_ev)
        flg_pchi_r <= 1'b1;
      else if (clr_pchi)
        flg_pchi_r <= 1'b0;
    end
  end
  // ==========================================================
  // Control register writes.
  always @(posedge clk_i) begin
    if (rst_i) begin
      sense_r <= `EIV_CTRL_RST;
      en_ext_r <= 1'b0;
      en_pclo_r <= 1'b0;
      en_pchi_r <= 1'b0;
      mask_lo_r <= {NLO{1'b0}};
      mask_hi_r <= {(NPC-NLO){1'b0}};
    end else if (wb_wr) begin
      case (ofs)
        `EIV_CTRL_OFS: sense_r <= wd[`EIV_SENSE_LSB+1:`EIV_SENSE_LSB];
        `EIV_ENABLE_OFS: begin
          en_ext_r <= wd[`EIV_EN_EXT_BIT];
          en_pclo_r <= wd[`EIV_EN_PCLO_BIT];
          en_pchi_r <= wd[`EIV_EN_PCHI_BIT];
        end
        `EIV_MASK_LO_OFS: mask_lo_r <= wd[NLO-1:0];
        `EIV_MASK_HI_OFS: mask_hi_r <= wd[NPC-NLO-1:0];
        default: sense_r <= sense_r;
      endcase
    end
  end
  // ==========================================================
  // Pending requests and vector choice.
  wire [`EIV_NUM_SRC-1:0] pend;
  assign pend[0] = ext_level_req | (flg_ext_r & en_ext_r);
  assign pend[1] = flg_pclo_r & en_pclo_r;
  assign pend[2] = flg_pchi_r & en_pchi_r;
  // Bits 3..15 map to 0x0004..0x0010 in table order.
  assign pend[`EIV_NUM_SRC-1:3] = periph_req_i;
  wire any_pend;
  wire [4:0] win_vec;
  eiv_prio_enc #(.N(`EIV_NUM_SRC)) u_enc (
    .req_i(pend),
    .any_o(any_pend),
    .vec_o(win_vec)
  );
  // Wake uses the synchronised pin level too, so a low level wakes with no I/O clock.
  wire wake_nxt = any_pend | (level_mode & en_ext_r & ext_low);
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_req_o <= 1'b0;
      irq_vec_o <= `EIV_VEC_RESET;
      wake_o <= 1'b0;
      reset_vec_o <= `EIV_VEC_RESET;
    end else begin
      irq_req_o <= any_pend;
      irq_vec_o <= win_vec;
      wake_o <= wake_nxt;
      reset_vec_o <= `EIV_VEC_RESET;
    end
  end
  // ==========================================================
  // Wishbone classic slave: one-cycle ack, unmapped reads return zero.
  reg [7:0] rd;
  always @* begin
    case (ofs)
      `EIV_CTRL_OFS: rd = {6'h00, sense_r};
      `EIV_ENABLE_OFS: rd = {1'b0, en_ext_r, en_pchi_r, en_pclo_r, 4'h0};
      `EIV_FLAG_OFS: rd = {1'b0, flg_ext_r, flg_pchi_r, flg_pclo_r, 4'h0};
      `EIV_MASK_LO_OFS: rd = mask_lo_r;
      `EIV_MASK_HI_OFS: rd = {{(8-NPC+NLO){1'b0}}, mask_hi_r};
      `EIV_PEND_OFS: rd = {7'h00, any_pend};
      `EIV_VECTOR_OFS: rd = {3'h0, win_vec};
      `EIV_STATUS_OFS: rd = {7'h00, ext_s2_r};
      default: rd = `EIV_BYTE_RST;
    endcase
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? {24'h000000, rd} : 32'h00000000;
    end
  end
endmodule

/* core/eiv_consts.vh */
// Constants for the external interrupt and vector block.
// Assumes a Wishbone classic slave with 32-bit data, byte-word offsets.
`ifndef EIV_CONSTS_VH
`define EIV_CONSTS_VH
// ==========================================================
// Register byte offsets
`define EIV_CTRL_OFS 8'h00
`define EIV_ENABLE_OFS 8'h04
`define EIV_FLAG_OFS 8'h08
`define EIV_MASK_LO_OFS 8'h0C
`define EIV_MASK_HI_OFS 8'h10
`define EIV_PEND_OFS 8'h14
`define EIV_VECTOR_OFS 8'h18
`define EIV_STATUS_OFS 8'h1C
// ==========================================================
// Field positions
`define EIV_SENSE_LSB 0
`define EIV_EN_EXT_BIT 6
`define EIV_EN_PCHI_BIT 5
`define EIV_EN_PCLO_BIT 4
`define EIV_FLG_EXT_BIT 6
`define EIV_FLG_PCHI_BIT 5
`define EIV_FLG_PCLO_BIT 4
// ==========================================================
// Sense modes
`define EIV_SENSE_LOW 2'h0
`define EIV_SENSE_ANY 2'h1
`define EIV_SENSE_FALL 2'h2
`define EIV_SENSE_RISE 2'h3
// ==========================================================
// Vector word addresses
`define EIV_VEC_RESET 5'h00
`define EIV_VEC_EXT 5'h01
`define EIV_VEC_PC_LO 5'h02
`define EIV_VEC_PC_HI 5'h03
`define EIV_VEC_WDOG 5'h04
`define EIV_VEC_T16_CAP 5'h05
`define EIV_VEC_T16_CMPA 5'h06
`define EIV_VEC_T16_CMPB 5'h07
`define EIV_VEC_T16_OVF 5'h08
`define EIV_VEC_T8_CMPA 5'h09
`define EIV_VEC_T8_CMPB 5'h0A
`define EIV_VEC_T8_OVF 5'h0B
`define EIV_VEC_COMP 5'h0C
`define EIV_VEC_CONV 5'h0D
`define EIV_VEC_NVM 5'h0E
`define EIV_VEC_SER_STR 5'h0F
`define EIV_VEC_SER_OVF 5'h10
`define EIV_NUM_SRC 16
// ==========================================================
// Reset values
`define EIV_CTRL_RST 2'h0
`define EIV_BYTE_RST 8'h00
`endif

/* core/eiv_prio_enc.v */
// Fixed-priority encoder from request bits to vector word address.
// Assumes bit 0 is vector 0x0001 and higher bits follow in order.
`timescale 1ns/1ps
`include "eiv_consts.vh"
module eiv_prio_enc #(
  parameter N = `EIV_NUM_SRC
) (
  input wire [N-1:0] req_i,
  output reg any_o,
  output reg [4:0] vec_o
);
  integer k;
  // ==========================================================
  // Lowest index wins, so scan downward and let lower bits overwrite.
  always @* begin
    any_o = 1'b0;
    vec_o = `EIV_VEC_RESET;
    for (k = N - 1; k >= 0; k = k - 1) begin
      if (req_i[k]) begin
        any_o = 1'b1;
        vec_o = k[4:0] + 5'h01;
      end
    end
  end
endmodule

/* bench/eiv_core_model.sv */
// Core model that fetches the winning vector and reports it taken.
// Assumes the block's registered request and vector outputs.
`timescale 1ns/1ps
module eiv_core_model (
  input wire clk_i,
  input wire take_en_i,
  input wire irq_req_i,
  input wire [4:0] irq_vec_i,
  output reg vec_taken_o,
  output reg [4:0] vec_taken_addr_o
);
  // ==========================================================
  // Fetch
  // Two idle cycles after each fetch, so the registered vector has moved on
  // and no stale vector is fetched a second time.
  reg gap_r;
  initial begin
    vec_taken_o = 1'b0;
    vec_taken_addr_o = 5'h00;
    gap_r = 1'b0;
  end
  always @(posedge clk_i) begin
    vec_taken_o <= take_en_i && irq_req_i && !vec_taken_o && !gap_r;
    gap_r <= vec_taken_o;
    vec_taken_addr_o <= irq_vec_i;
  end
endmodule

/* bench/eiv_top_checker.sv */
// Concurrent checks on the ports of the interrupt and vector block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module eiv_top_checker (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [12:0] periph_req_i,
  input wire irq_req_o,
  input wire [4:0] irq_vec_o,
  input wire [4:0] reset_vec_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // Helper
  // Counts edges since reset so no history from reset is trusted.
  reg [1:0] run_r;
  always @(posedge clk_i) begin
    run_r <= rst_i ? 2'h0 : (run_r == 2'h3 ? run_r : run_r + 2'h1);
  end
  // ==========================================================
  // Assertions
  reset_vec_a: assert property (reset_vec_o == 5'h00)
    else $error("reset vector not zero");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  vec_range_a: assert property (irq_req_o |-> irq_vec_o inside {[1:16]})
    else $error("vector outside table");
  wdog_prio_a: assert property (run_r == 2'h3 && $past(periph_req_i[0])
    && $past(periph_req_i[0], 2) |-> irq_req_o && irq_vec_o <= 5'h04)
    else $error("watchdog request not served in order");
  ser_ovf_a: assert property (run_r == 2'h3 && $past(periph_req_i[12])
    && $past(periph_req_i[12], 2) |-> irq_req_o)
    else $error("serial overflow request lost");
  cover property (irq_req_o && irq_vec_o == 5'h01);
  cover property (irq_req_o && irq_vec_o == 5'h02);
  cover property (irq_req_o && irq_vec_o == 5'h10);
endmodule
bind eiv_top eiv_top_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .periph_req_i(periph_req_i), .irq_req_o(irq_req_o),
  .irq_vec_o(irq_vec_o), .reset_vec_o(reset_vec_o));

/* bench/tb_top.sv */
// Self-checking bench for the interrupt and vector block.
// Assumes the core model and the checker are compiled before it.
`timescale 1ns/1ps
`include "eiv_consts.vh"
module tb_top;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg [31:0] adr = 32'h0;
  reg [31:0] wdat = 32'h0;
  reg [3:0] sel = 4'h0;
  reg we = 1'b0;
  reg cyc = 1'b0;
  reg ext = 1'b1;
  reg [11:0] pins = 12'h001;
  reg io_run = 1'b1;
  reg [12:0] preq = 13'h0;
  reg take_en = 1'b0;
  reg [31:0] q;
  wire [31:0] rdat;
  wire ack, irq, wake, taken;
  wire [4:0] vec, rvec, taddr;
  integer fails = 0;
  integer checks_done = 0;
  integer i, m, b;
  always #50 clk_i = ~clk_i;
  eiv_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .ext_irq_pin_i(ext),
    .pin_change_inputs_i(pins), .io_clk_run_i(io_run), .periph_req_i(preq),
    .vec_taken_i(taken), .vec_taken_addr_i(taddr), .irq_req_o(irq),
    .irq_vec_o(vec), .wake_o(wake), .reset_vec_o(rvec));
  eiv_core_model i_core (.clk_i(clk_i), .take_en_i(take_en),
    .irq_req_i(irq), .irq_vec_i(vec), .vec_taken_o(taken),
    .vec_taken_addr_o(taddr));
  // ==========================================================
  // Tasks
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input [7:0] a, input w, input [7:0] d, input [3:0] s);
    integer n;
    begin
      adr <= {24'h0, a};
      we <= w;
      wdat <= {24'h0, d};
      sel <= s;
      cyc <= 1'b1;
      n = 0;
      do begin
        @(posedge clk_i);
        n = n + 1;
      end while (ack !== 1'b1 && n < 20);
      if (ack !== 1'b1) begin
        fails = fails + 1;
        complete_run;
      end
      q = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask
  task rc(input string nm, input [7:0] a, input [7:0] e);
    begin
      bus(a, 1'b0, 8'h00, 4'hF);
      chk(nm, {24'h0, e}, q);
    end
  endtask
  task settle;
    repeat (5) @(posedge clk_i);
  endtask
  function [7:0] exp_ext(input integer md, input fall);
    exp_ext = (md == 1 || (md == 2) == fall) ? 8'h40 : 8'h00;
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    m = $urandom(30);
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(`EIV_MASK_LO_OFS, 1'b1, 8'hFF, 4'hE);
    wr(8'h40, 8'hFF);
    for (i = 0; i < 9; i = i + 1)
      rc("reset read", 8'(i < 8 ? i * 4 : 64), {7'h0, i == 7});
    chk("reset vector", 32'h0, {27'h0, rvec});
    $display("test reset done");
    m = ($urandom & 8'hFC) | 8'h01;
    wr(`EIV_MASK_LO_OFS, m[7:0]);
    wr(`EIV_ENABLE_OFS, 8'h10);
    pins[1] <= ~pins[1];
    settle;
    rc("masked pin", `EIV_FLAG_OFS, 8'h00);
    io_run <= 1'b0;
    pins[0] <= ~pins[0];
    settle;
    rc("low group", `EIV_FLAG_OFS, 8'h10);
    chk("low vector", 32'h2, {27'h0, vec});
    io_run <= 1'b1;
    wr(`EIV_FLAG_OFS, 8'h10);
    rc("flag clear", `EIV_FLAG_OFS, 8'h00);
    wr(`EIV_ENABLE_OFS, 8'h00);
    pins[0] <= ~pins[0];
    settle;
    rc("group off", `EIV_FLAG_OFS, 8'h00);
    wr(`EIV_MASK_HI_OFS, 8'h08);
    wr(`EIV_ENABLE_OFS, 8'h30);
    pins <= pins ^ 12'h801;
    settle;
    rc("both groups", `EIV_FLAG_OFS, 8'h30);
    chk("lowest first", 32'h2, {27'h0, vec});
    take_en <= 1'b1;
    repeat (14) @(posedge clk_i);
    take_en <= 1'b0;
    rc("taken clear", `EIV_FLAG_OFS, 8'h00);
    $display("test pin change done");
    wr(`EIV_ENABLE_OFS, 8'h40);
    for (m = 1; m < 4; m = m + 1) begin
      wr(`EIV_CTRL_OFS, m[7:0]);
      wr(`EIV_FLAG_OFS, 8'h40);
      ext <= 1'b0;
      settle;
      rc("fall edge", `EIV_FLAG_OFS, exp_ext(m, 1'b1));
      wr(`EIV_FLAG_OFS, 8'h40);
      ext <= 1'b1;
      settle;
      rc("rise edge", `EIV_FLAG_OFS, exp_ext(m, 1'b0));
    end
    io_run <= 1'b0;
    wr(`EIV_CTRL_OFS, 8'h02);
    // The rising-edge pass leaves its flag set; clear it first.
    wr(`EIV_FLAG_OFS, 8'h40);
    ext <= 1'b0;
    settle;
    rc("no io clock", `EIV_FLAG_OFS, 8'h00);
    ext <= 1'b1;
    io_run <= 1'b1;
    settle;
    wr(`EIV_CTRL_OFS, 8'h00);
    ext <= 1'b0;
    settle;
    chk("level req", {26'h0, 5'h01, 1'b1}, {26'h0, vec, irq});
    chk("wake", 32'h1, {31'h0, wake});
    rc("level flag", `EIV_FLAG_OFS, 8'h00);
    ext <= 1'b1;
    settle;
    chk("level gone", 32'h0, {31'h0, irq});
    $display("test dedicated pin done");
    for (i = 0; i < 6; i = i + 1) begin
      b = i < 2 ? i * 12 : $urandom % 13;
      preq <= 13'h1 << b;
      settle;
      chk("peripheral vector", 32'h4 + b, {27'h0, vec});
      preq <= 13'h0;
      @(posedge clk_i);
    end
    $display("test vectors done");
    complete_run;
  end
  initial begin
    #10000000;
    fails = fails + 1;
    complete_run;
  end
endmodule
